// >>> logic/tts_regs.svh
// register offsets, field positions, reset values and counts of the trace trigger sequencer
// Summary of operation
// - each term matches its own primary qualifier
// - one shared restart qualifier for all terms
// - trigger on primary branch out of last term
// - primary branch advances exactly one term
// - restart match returns to term one
// - after trigger store 511, 255 or 0 more states (start, centre, end), stop
// - stored states flag sequencer branch states
// - easy sequencer holds at most four terms
// - insert before existing term, else append any
// - delete renumbers later terms down by one
// - store-never qualifier still stores branch states
// - programmable trigger position, centre splits memory
// - entering complex mode reinitialises all settings
// - easy mode clears patterns, position, count, prestore
// - eight pattern comparators plus one range
// - comparators in two sets, set operators combine
// - pattern always, never, AND-equal or OR-unequal
// - occurrence count must match before primary branch
// - branch states always stored
// - reset leaves exactly one sequence term
`ifndef TTS_REGS_SVH
`define TTS_REGS_SVH
`define TTS_OFF_CTRL      8'h00
`define TTS_OFF_CFG       8'h04
`define TTS_OFF_STATUS    8'h08
`define TTS_OFF_SEQCMD    8'h0C
`define TTS_OFF_STOREQ    8'h10
`define TTS_OFF_RESTARTQ  8'h14
`define TTS_OFF_COUNTQ    8'h18
`define TTS_OFF_PREQ      8'h1C
`define TTS_OFF_RANGE_LO  8'h20
`define TTS_OFF_RANGE_HI  8'h24
`define TTS_OFF_EVCOUNT   8'h28
`define TTS_OFF_TERM_BASE 8'h40
`define TTS_OFF_PAT_BASE  8'h80
`define TTS_CTRL_START    0
`define TTS_CTRL_STOP     1
`define TTS_CFG_COMPLEX   0
`define TTS_CFG_TP_LSB    2
`define TTS_CMD_INSERT    2'h1
`define TTS_CMD_DELETE    2'h2
`define TTS_CMD_RESET     2'h3
`define TTS_QUAL_ANY      14'h0040
`define TTS_QUAL_NEVER    14'h0000
`define TTS_MAX_TERMS     3'h4
`define TTS_DEPTH         10'h200
`define TTS_TP_START      2'h0
`define TTS_TP_CENTER     2'h1
`define TTS_TP_END        2'h2
`endif

// >>> logic/tts_pkg.sv
// types shared by the trace trigger sequencer
package tts_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [15:0] stat;
  } tts_state_t;
  typedef struct packed {
    logic       branch;
    logic       prestore;
    tts_state_t st;
  } tts_rec_t;
  // set a: bits 3:0 patterns one..four, bit 4 range; set b: patterns five..eight
  typedef struct packed {
    logic [1:0] comb;
    logic       nor_b;
    logic [3:0] set_b;
    logic       nor_a;
    logic       neg_r;
    logic [4:0] set_a;
  } tts_qual_t;
  typedef enum logic [1:0] {
    TTS_PM_NEVER  = 2'b00,
    TTS_PM_ALWAYS = 2'b01,
    TTS_PM_AND_EQ = 2'b10,
    TTS_PM_OR_NE  = 2'b11
  } tts_pmode_t;
  typedef enum logic [1:0] {
    TTS_IDLE = 2'b00,
    TTS_PRE  = 2'b01,
    TTS_POST = 2'b10,
    TTS_DONE = 2'b11
  } tts_run_t;
endpackage

// >>> logic/tts_sequencer.sv
// trace trigger sequencer with state qualifiers and apb register file
`timescale 1ns/1ns
`default_nettype none
`include "tts_regs.svh"
module tts_sequencer
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // captured bus states
  input  wire logic        cap_valid,
  input  wire tts_state_t  cap_state,
  // trace memory write port
  output logic             rec_valid_ff,
  output logic [8:0]       rec_addr_ff,
  output tts_rec_t         rec_ff,
  output logic             trig_ff
);
  logic [3:0]  pat_ctrl_ff [8];
  logic [31:0] pat_val_ff  [8];
  logic [31:0] pat_mask_ff [8];
  tts_qual_t   tq_ff [4];
  logic [15:0] tc_ff [4];
  tts_qual_t   storeq_ff, restartq_ff, countq_ff, preq_ff;
  logic [31:0] rlo_ff, rhi_ff, evcount_ff;
  logic        complex_ff;
  logic [1:0]  trigger_position_select_ff;
  logic [2:0]  nterms_ff, term_ff;
  logic [15:0] occ_ff;
  logic [9:0]  post_ff;
  tts_run_t    run_ff;
  logic [7:0]  pmatch;
  logic        rmatch;

  // apb decode: zero wait states
  logic wr, acc, hit_term, hit_pat, go_cx, go_ez, cmd_ok, idle;
  logic [1:0] tidx;
  logic [2:0] pidx;
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign pready   = 1'b1;
  assign hit_term = paddr[7:6] == 2'b01 && paddr[5] == 1'b0 && paddr[1:0] == 2'b00
                    && paddr[2] == 1'b0 || paddr[7:6] == 2'b01 && paddr[5] == 1'b0
                    && paddr[1:0] == 2'b00;
  assign tidx     = paddr[4:3];
  assign hit_pat  = paddr[7] && paddr[3:0] != 4'hC && paddr[1:0] == 2'b00;
  assign pidx     = paddr[6:4];
  assign idle     = run_ff == TTS_IDLE || run_ff == TTS_DONE;
  assign go_cx    = wr && paddr == `TTS_OFF_CFG && pwdata[`TTS_CFG_COMPLEX] && !complex_ff;
  assign go_ez    = wr && paddr == `TTS_OFF_CFG && !pwdata[`TTS_CFG_COMPLEX] && complex_ff;
  // term edits are refused while a trace runs
  assign cmd_ok   = wr && paddr == `TTS_OFF_SEQCMD && idle;

  always_comb begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    if (hit_term) begin
      prdata = paddr[2] ? {16'h0, tc_ff[tidx]} : {18'h0, tq_ff[tidx]};
    end else if (hit_pat) begin
      unique case (paddr[3:2])
        2'h0: prdata = {28'h0, pat_ctrl_ff[pidx]};
        2'h1: prdata = pat_val_ff[pidx];
        default: prdata = pat_mask_ff[pidx];
      endcase
    end else begin
      unique case (paddr)
        `TTS_OFF_CTRL, `TTS_OFF_SEQCMD: prdata = 32'h0;
        `TTS_OFF_CFG:      prdata = {28'h0, trigger_position_select_ff, 1'b0, complex_ff};
        `TTS_OFF_STATUS:   prdata = {occ_ff, 5'h0, nterms_ff, 1'b0, term_ff + 3'h1,
                                     2'h0, run_ff};
        `TTS_OFF_STOREQ:   prdata = {18'h0, storeq_ff};
        `TTS_OFF_RESTARTQ: prdata = {18'h0, restartq_ff};
        `TTS_OFF_COUNTQ:   prdata = {18'h0, countq_ff};
        `TTS_OFF_PREQ:     prdata = {18'h0, preq_ff};
        `TTS_OFF_RANGE_LO: prdata = rlo_ff;
        `TTS_OFF_RANGE_HI: prdata = rhi_ff;
        `TTS_OFF_EVCOUNT:  prdata = evcount_ff;
        default:           pslverr = acc;
      endcase
    end
  end

  // pattern comparators, one per entry
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pat
      logic [31:0] lab;
      logic        eq;
      always_comb begin
        unique case (pat_ctrl_ff[gi][3:2])
          2'h0:    lab = cap_state.addr;
          2'h1:    lab = cap_state.data;
          default: lab = {16'h0, cap_state.stat};
        endcase
      end
      assign eq = ((lab ^ pat_val_ff[gi]) & pat_mask_ff[gi]) == 32'h0;
      always_comb begin
        unique case (tts_pmode_t'(pat_ctrl_ff[gi][1:0]))
          TTS_PM_NEVER:  pmatch[gi] = 1'b0;
          TTS_PM_ALWAYS: pmatch[gi] = 1'b1;
          TTS_PM_AND_EQ: pmatch[gi] = eq;
          TTS_PM_OR_NE:  pmatch[gi] = !eq;
        endcase
      end
    end
  endgenerate
  assign rmatch = cap_state.addr >= rlo_ff && cap_state.addr <= rhi_ff;

  // within a set: or / nor; between sets: and / or
  function automatic logic qual_eval(input tts_qual_t q, input logic [7:0] pm,
                                     input logic rm);
    logic [4:0] ra;
    logic       a, b;
    ra = {rm ^ q.neg_r, pm[3:0]} & q.set_a;
    a  = q.nor_a ? ~|ra : |ra;
    b  = q.nor_b ? ~|(pm[7:4] & q.set_b) : |(pm[7:4] & q.set_b);
    unique case (q.comb)
      2'h0: qual_eval = a;
      2'h1: qual_eval = b;
      2'h2: qual_eval = a & b;
      2'h3: qual_eval = a | b;
    endcase
  endfunction

  // all decisions are combinational in the capture cycle
  logic seq_on, q_prim, q_rst, q_sto, q_pre, prim_hit, occ_done, take_prim;
  logic restart, branch, last, trig, store;
  assign seq_on    = cap_valid && run_ff == TTS_PRE;
  assign q_prim    = qual_eval(tq_ff[term_ff[1:0]], pmatch, rmatch);
  assign q_rst     = qual_eval(restartq_ff, pmatch, rmatch);
  assign q_sto     = qual_eval(storeq_ff, pmatch, rmatch);
  assign q_pre     = qual_eval(preq_ff, pmatch, rmatch);
  assign prim_hit  = seq_on && q_prim;
  assign occ_done  = occ_ff <= 16'h1;
  assign take_prim = prim_hit && occ_done;
  // a completed primary match wins over a restart in the same state
  assign restart   = seq_on && q_rst && !take_prim;
  assign branch    = take_prim || restart;
  assign last      = term_ff == nterms_ff - 3'h1;
  assign trig      = take_prim && last;
  assign store     = cap_valid && (run_ff == TTS_PRE || run_ff == TTS_POST)
                     && (q_sto || branch || q_pre);

  // configuration, qualifiers and patterns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complex_ff <= 1'b0;
    end else if (wr && paddr == `TTS_OFF_CFG) begin
      complex_ff <= pwdata[`TTS_CFG_COMPLEX];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trigger_position_select_ff <= `TTS_TP_START;
      storeq_ff   <= `TTS_QUAL_ANY;
      restartq_ff <= `TTS_QUAL_NEVER;
      countq_ff   <= `TTS_QUAL_ANY;
      preq_ff     <= `TTS_QUAL_NEVER;
      rlo_ff      <= 32'h0;
      rhi_ff      <= 32'h0;
      for (int i = 0; i < 8; i++) begin
        pat_ctrl_ff[i] <= 4'h0;
        pat_val_ff[i]  <= 32'h0;
        pat_mask_ff[i] <= 32'h0;
      end
    end else if (go_cx || go_ez) begin
      trigger_position_select_ff <= `TTS_TP_START;
      countq_ff <= `TTS_QUAL_ANY;
      preq_ff   <= `TTS_QUAL_NEVER;
      for (int i = 0; i < 8; i++) begin
        pat_ctrl_ff[i] <= 4'h0;
        pat_val_ff[i]  <= 32'h0;
        pat_mask_ff[i] <= 32'h0;
      end
      if (go_cx) begin
        storeq_ff   <= `TTS_QUAL_ANY;
        restartq_ff <= `TTS_QUAL_NEVER;
        rlo_ff      <= 32'h0;
        rhi_ff      <= 32'h0;
      end
    end else if (wr) begin
      if (hit_pat) begin
        unique case (paddr[3:2])
          2'h0: pat_ctrl_ff[pidx] <= pwdata[3:0];
          2'h1: pat_val_ff[pidx]  <= pwdata;
          default: pat_mask_ff[pidx] <= pwdata;
        endcase
      end
      if (paddr == `TTS_OFF_CFG) trigger_position_select_ff <= pwdata[3:2];
      if (paddr == `TTS_OFF_STOREQ) storeq_ff <= pwdata[13:0];
      if (paddr == `TTS_OFF_RESTARTQ) restartq_ff <= pwdata[13:0];
      if (paddr == `TTS_OFF_COUNTQ) countq_ff <= pwdata[13:0];
      if (paddr == `TTS_OFF_PREQ) preq_ff <= pwdata[13:0];
      if (paddr == `TTS_OFF_RANGE_LO) rlo_ff <= pwdata;
      if (paddr == `TTS_OFF_RANGE_HI) rhi_ff <= pwdata;
    end
  end

  // sequence term list: insert, delete, reset, direct writes
  logic [2:0] ck;
  assign ck = pwdata[4:2] - 3'h1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nterms_ff <= 3'h1;
      for (int i = 0; i < 4; i++) begin
        tq_ff[i] <= `TTS_QUAL_ANY;
        tc_ff[i] <= 16'h1;
      end
    end else if (go_cx || cmd_ok && pwdata[1:0] == `TTS_CMD_RESET) begin
      nterms_ff <= 3'h1;
      for (int i = 0; i < 4; i++) begin
        tq_ff[i] <= `TTS_QUAL_ANY;
        tc_ff[i] <= 16'h1;
      end
    end else if (cmd_ok && pwdata[1:0] == `TTS_CMD_INSERT) begin
      if (nterms_ff < `TTS_MAX_TERMS) begin
        nterms_ff <= nterms_ff + 3'h1;
        for (int i = 1; i < 4; i++) begin
          if (i > ck && ck < nterms_ff) begin
            tq_ff[i] <= tq_ff[i-1];
            tc_ff[i] <= tc_ff[i-1];
          end
        end
        tq_ff[(ck < nterms_ff) ? ck[1:0] : nterms_ff[1:0]] <= `TTS_QUAL_ANY;
        tc_ff[(ck < nterms_ff) ? ck[1:0] : nterms_ff[1:0]] <= 16'h1;
      end
    end else if (cmd_ok && pwdata[1:0] == `TTS_CMD_DELETE) begin
      if (nterms_ff > 3'h1 && ck < nterms_ff) begin
        nterms_ff <= nterms_ff - 3'h1;
        for (int i = 0; i < 3; i++) begin
          if (i >= ck) begin
            tq_ff[i] <= tq_ff[i+1];
            tc_ff[i] <= tc_ff[i+1];
          end
        end
        tq_ff[3] <= `TTS_QUAL_ANY;
        tc_ff[3] <= 16'h1;
      end
    end else if (wr && hit_term && idle) begin
      if (paddr[2]) tc_ff[tidx] <= pwdata[15:0];
      else tq_ff[tidx] <= pwdata[13:0];
    end
  end

  // run control and sequencer position
  logic [9:0] post_len;
  always_comb begin
    unique case (trigger_position_select_ff)
      `TTS_TP_START:  post_len = `TTS_DEPTH - 10'h1;
      `TTS_TP_CENTER: post_len = (`TTS_DEPTH >> 1) - 10'h1;
      default:        post_len = 10'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ff  <= TTS_IDLE;
      term_ff <= 3'h0;
      occ_ff  <= 16'h1;
      post_ff <= 10'h0;
    end else if (wr && paddr == `TTS_OFF_CTRL && pwdata[`TTS_CTRL_START]) begin
      run_ff  <= TTS_PRE;
      term_ff <= 3'h0;
      occ_ff  <= tc_ff[0];
    end else if (go_cx || wr && paddr == `TTS_OFF_CTRL && pwdata[`TTS_CTRL_STOP]) begin
      run_ff <= TTS_DONE;
    end else begin
      unique case (run_ff)
        TTS_PRE: begin
          if (trig) begin
            term_ff <= term_ff + 3'h1;
            post_ff <= post_len;
            run_ff  <= (post_len == 10'h0) ? TTS_DONE : TTS_POST;
          end else if (take_prim) begin
            term_ff <= term_ff + 3'h1;
            occ_ff  <= tc_ff[term_ff[1:0] + 2'h1];
          end else if (restart) begin
            term_ff <= 3'h0;
            occ_ff  <= tc_ff[0];
          end else if (prim_hit) begin
            occ_ff <= occ_ff - 16'h1;
          end
        end
        TTS_POST: begin
          if (store) begin
            post_ff <= post_ff - 10'h1;
            if (post_ff == 10'h1) run_ff <= TTS_DONE;
          end
        end
        TTS_IDLE, TTS_DONE: begin
          run_ff <= run_ff;
        end
      endcase
    end
  end

  // trace memory write port and count qualifier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_valid_ff <= 1'b0;
      rec_addr_ff  <= 9'h1FF;
      rec_ff       <= '0;
      trig_ff      <= 1'b0;
      evcount_ff   <= 32'h0;
    end else begin
      rec_valid_ff <= store;
      trig_ff      <= trig && run_ff == TTS_PRE;
      if (store) begin
        rec_addr_ff <= rec_addr_ff + 9'h1;
        rec_ff      <= {branch, q_pre && !q_sto && !branch, cap_state};
      end
      if (wr && paddr == `TTS_OFF_CTRL && pwdata[`TTS_CTRL_START]) begin
        evcount_ff <= 32'h0;
      end else if (cap_valid && run_ff != TTS_IDLE && run_ff != TTS_DONE
                   && qual_eval(countq_ff, pmatch, rmatch)) begin
        evcount_ff <= evcount_ff + 32'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_branch_next: assert property (take_prim && !last && !wr |=> term_ff == $past(term_ff) + 3'h1)
    else $error("primary branch did not advance one term");
  chk_restart_one: assert property (restart && !wr |=> term_ff == 3'h0)
    else $error("restart did not return to term one");
  chk_trig_last: assert property (trig_ff |-> $past(term_ff) == $past(nterms_ff) - 3'h1)
    else $error("trigger not from last term");
  chk_term_limit: assert property (nterms_ff >= 3'h1 && nterms_ff <= `TTS_MAX_TERMS)
    else $error("term count out of range");
  chk_branch_stored: assert property (branch |=> rec_valid_ff && rec_ff.branch)
    else $error("branch state not stored with flag");
  chk_never_store: assert property (cap_valid && !q_sto && !branch && !q_pre |=> !rec_valid_ff)
    else $error("unqualified state stored");
  chk_done_quiet: assert property (run_ff == TTS_DONE && !wr |=> !rec_valid_ff ##1 !rec_valid_ff)
    else $error("storage continued after stop");
  chk_occ_count: assert property (prim_hit && !occ_done && !restart && !wr |=> occ_ff == $past(occ_ff) - 16'h1)
    else $error("occurrence count not decremented");
  chk_seq_reset: assert property (go_cx |=> nterms_ff == 3'h1 && tq_ff[0] == `TTS_QUAL_ANY)
    else $error("complex entry did not reinitialise terms");
endmodule
`default_nettype wire

// >>> tb/tts_bus_model.sv
// capture-side model: presents processor bus states to the sequencer
`timescale 1ns/1ns
`default_nettype none
module tts_bus_model
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // captured states
  output logic       cap_valid,
  output tts_state_t cap_state
);
  initial begin
    cap_valid = 1'b0;
    cap_state = '0;
  end
  // one state per call; lines are inverted between states so stale data never looks valid
  task automatic send_full(input logic [31:0] a, input logic [31:0] d, input logic [15:0] s);
    do @(posedge pclk); while (!presetn);
    cap_valid <= 1'b1;
    cap_state <= '{addr: a, data: d, stat: s};
    @(posedge pclk);
    cap_valid <= 1'b0;
    cap_state <= ~cap_state;
  endtask
  // address-only state: data is the inverted address, status is fixed at 16'h0001
  task automatic send(input logic [31:0] a);
    send_full(a, ~a, 16'h0001);
  endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the trace trigger sequencer over apb
`timescale 1ns/1ns
`default_nettype none
module tb
  import tts_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cap_valid;
  tts_state_t  cap_state;
  logic        rec_valid_ff;
  logic [8:0]  rec_addr_ff;
  tts_rec_t    rec_ff;
  logic        trig_ff;
  logic        slv;
  logic [31:0] q;
  logic [31:0] last_addr;
  logic [31:0] pv [3];
  logic [7:0]  pa [3];
  int          err_total;
  int          checks_done;
  int          n_rec;
  int          n_br;
  int          n_trig;
  int          cyc;

  tts_sequencer i_tts_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap_valid(cap_valid), .cap_state(cap_state),
    .rec_valid_ff(rec_valid_ff), .rec_addr_ff(rec_addr_ff), .rec_ff(rec_ff),
    .trig_ff(trig_ff));
  tts_bus_model i_tts_bus_model (.pclk(pclk), .presetn(presetn), .cap_valid(cap_valid),
    .cap_state(cap_state));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic stop_test;
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // the answer is awaited, never assumed: only the cycle ceiling ends a stall
  always @(posedge pclk) begin
    cyc++;
    if (rec_valid_ff === 1'b1) begin
      n_rec++;
      last_addr = rec_ff.st.addr;
      if (rec_ff.branch === 1'b1) n_br++;
    end
    if (trig_ff === 1'b1) n_trig++;
    if (cyc == 5000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    ck($sformatf("reg %h", a), e, q & m);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    pv = '{32'h0000_0A04, 32'h0000_0118, 32'h0000_0A1A};
    pa = '{8'h80, 8'h90, 8'hF0};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h08, 32'h0000_0703, 32'h0000_0100);
    rc(8'h8C, 32'hFFFF_FFFF, 32'h0);
    ck("pslverr", 32'h1, {31'h0, slv});
    wr(8'h40, 32'h1);
    wr(8'h0C, 32'h9);
    rc(8'h08, 32'h700, 32'h200);
    rc(8'h48, 32'hFFFF, 32'h40);
    wr(8'h0C, 32'h5);
    rc(8'h40, 32'hFFFF, 32'h40);
    rc(8'h48, 32'hFFFF, 32'h1);
    wr(8'h0C, 32'h5);
    wr(8'h0C, 32'h5);
    rc(8'h08, 32'h700, 32'h400);
    wr(8'h0C, 32'h6);
    wr(8'h0C, 32'h6);
    rc(8'h08, 32'h700, 32'h200);
    rc(8'h40, 32'hFFFF, 32'h1);
    // patterns one, two and eight compare the address exactly
    for (int p = 0; p < 3; p++) begin
      wr(pa[p], 32'h2);
      wr(pa[p] + 8'h4, pv[p]);
      wr(pa[p] + 8'h8, 32'hFFFF_FFFF);
    end
    wr(8'h48, 32'h2);
    wr(8'h44, 32'h2);
    wr(8'h14, 32'h1400);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h4);
    wr(8'h00, 32'h1);
    rc(8'h08, 32'hFFFF_0073, 32'h0002_0011);
    i_tts_bus_model.send(32'hA04);
    rc(8'h08, 32'hFFFF_0070, 32'h0001_0010);
    i_tts_bus_model.send(32'hA04);
    rc(8'h08, 32'h70, 32'h20);
    i_tts_bus_model.send(32'hA1A);
    rc(8'h08, 32'h70, 32'h10);
    i_tts_bus_model.send(32'h118);
    rc(8'h08, 32'h70, 32'h10);
    i_tts_bus_model.send(32'hA04);
    i_tts_bus_model.send(32'hA04);
    i_tts_bus_model.send(32'h118);
    repeat (2) @(posedge pclk);
    rc(8'h08, 32'h73, 32'h32);
    ck("records", 32'd4, n_rec);
    ck("branch flags", 32'd4, n_br);
    ck("triggers", 32'd1, n_trig);
    ck("record addr", 32'h118, last_addr);
    wr(8'h10, 32'h40);
    for (int i = 0; i < 254; i++) i_tts_bus_model.send(32'h1000 + i);
    rc(8'h08, 32'h3, 32'h2);
    i_tts_bus_model.send(32'h2000);
    rc(8'h08, 32'h3, 32'h3);
    ck("records", 32'd259, n_rec);
    i_tts_bus_model.send(32'h2001);
    repeat (2) @(posedge pclk);
    ck("records", 32'd259, n_rec);
    ck("record index", 32'h102, {23'h0, rec_addr_ff});
    rc(8'h28, 32'hFFFF_FFFF, 32'h106);
    wr(8'h0C, 32'h3);
    rc(8'h08, 32'h700, 32'h100);
    wr(8'h04, 32'h1);
    rc(8'h14, 32'hFFFF, 32'h0);
    wr(8'h80, 32'h1);
    wr(8'h18, 32'h1);
    wr(8'h1C, 32'h1);
    wr(8'h10, 32'h1);
    wr(8'h04, 32'h0);
    rc(8'h80, 32'h3, 32'h0);
    rc(8'h18, 32'hFFFF, 32'h40);
    rc(8'h1C, 32'hFFFF, 32'h0);
    rc(8'h10, 32'hFFFF, 32'h1);
    // data and status labels, the address range, and a term that joins both sets
    wr(8'h80, 32'h6);
    wr(8'h84, 32'h55AA_0000);
    wr(8'h88, 32'hFFFF_0000);
    wr(8'hC0, 32'hB);
    wr(8'hC4, 32'h2);
    wr(8'hC8, 32'hFFFF);
    wr(8'h20, 32'h300);
    wr(8'h24, 32'h3FF);
    wr(8'h40, 32'h2091);
    wr(8'h10, 32'h0);
    wr(8'h04, 32'h8);
    wr(8'h00, 32'h1);
    i_tts_bus_model.send_full(32'h350, 32'h0, 16'h2);
    i_tts_bus_model.send_full(32'h100, 32'h55AA_1234, 16'h2);
    i_tts_bus_model.send_full(32'h100, 32'h0, 16'h1);
    i_tts_bus_model.send_full(32'h3FF, 32'h0, 16'h1);
    repeat (2) @(posedge pclk);
    rc(8'h08, 32'h3, 32'h3);
    rc(8'h28, 32'hFFFF_FFFF, 32'h4);
    ck("records", 32'd260, n_rec);
    ck("triggers", 32'd2, n_trig);
    ck("record addr", 32'h3FF, last_addr);
    // reset in mid-run must leave the power-up state
    wr(8'h00, 32'h1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'h08, 32'hFFFF_07FF, 32'h0001_0110);
    rc(8'h04, 32'hF, 32'h0);
    ck("record index", 32'h1FF, {23'h0, rec_addr_ff});
    stop_test();
  end
endmodule
`default_nettype wire
